// file: src/dsc_pkg.sv
// package for the dual serial controller pin-level model
package dsc_pkg;
    localparam int DSC_DW = 8;
    localparam int DSC_AW = 6;
    localparam int DSC_NREG = 64;
    localparam int DSC_CLK_MHZ = 250;
    // device register map, byte offsets on the six select lines
    localparam logic [5:0] DSC_REG_CTRL_A = 6'h00;
    localparam logic [5:0] DSC_REG_CTRL_B = 6'h01;
    localparam logic [5:0] DSC_REG_CLKSEL_A = 6'h02;
    localparam logic [5:0] DSC_REG_CLKSEL_B = 6'h03;
    localparam logic [5:0] DSC_REG_IE = 6'h04;
    localparam logic [5:0] DSC_REG_VEC = 6'h05;
    localparam logic [5:0] DSC_REG_TXD_A = 6'h06;
    localparam logic [5:0] DSC_REG_TXD_B = 6'h07;
    localparam logic [5:0] DSC_REG_RXD_A = 6'h08;
    localparam logic [5:0] DSC_REG_RXD_B = 6'h09;
    localparam logic [5:0] DSC_REG_GSR = 6'h0A;
    localparam logic [5:0] DSC_REG_ICR = 6'h0B;
    // channel control fields
    localparam int DSC_CTRL_TXEN = 0;
    localparam int DSC_CTRL_RXEN = 1;
    localparam int DSC_CTRL_LOCLOOP = 2;
    localparam int DSC_CTRL_CTSEN = 3;
    localparam int DSC_CTRL_BOPLOOP = 4;
    localparam int DSC_CTRL_LOOPON = 5;
    localparam int DSC_CTRL_EXTRX = 6;
    localparam int DSC_CTRL_EXTTX = 7;
    // status bits: per channel rx ready, tx empty, cts change
    localparam int DSC_ST_RXRDY_A = 0;
    localparam int DSC_ST_TXMT_A = 1;
    localparam int DSC_ST_CTS_A = 2;
    localparam int DSC_ST_RXRDY_B = 4;
    localparam int DSC_ST_TXMT_B = 5;
    localparam int DSC_ST_CTS_B = 6;
    // interrupt control fields
    localparam int DSC_ICR_ACKLO = 0;
    localparam int DSC_ICR_MODVEC = 2;
    localparam int DSC_ICR_CHAIN = 3;
    localparam logic [1:0] DSC_ACK_FLOAT = 2'h0;
    localparam logic [1:0] DSC_ACK_VECTOR = 2'h1;
    localparam logic [1:0] DSC_ACK_CALL = 2'h2;
    localparam logic [1:0] DSC_ACK_ZERO = 2'h3;
    localparam logic [7:0] DSC_CALL_OP = 8'hCD;
    localparam logic [7:0] DSC_VEC_RST = 8'h0F;
    // clock pin output selects (low 4 bits pin a, high 4 bits pin b)
    localparam logic [3:0] DSC_CK_INPUT = 4'h0;
    localparam logic [3:0] DSC_CK_CT = 4'h1;
    localparam logic [3:0] DSC_CK_TX1X = 4'h2;
    localparam logic [3:0] DSC_CK_RX1X = 4'h3;
    localparam logic [3:0] DSC_CK_PLL = 4'h4;
    localparam logic [3:0] DSC_CK_TX16 = 4'h5;
    localparam logic [3:0] DSC_CK_RX16 = 4'h6;
    localparam logic [3:0] DSC_CK_SYS = 4'h7;
    // timing: internal bit-rate divider per half period
    localparam int DSC_BRG_DIV = 8;
    // host controller command port offsets
    localparam logic [1:0] DSC_HC_ADDR = 2'h0;
    localparam logic [1:0] DSC_HC_DATA = 2'h1;
    localparam logic [1:0] DSC_HC_CMD = 2'h2;
    localparam logic [1:0] DSC_HC_STAT = 2'h3;
    localparam int DSC_HC_CMD_RD = 0;
    localparam int DSC_HC_CMD_WR = 1;
    localparam int DSC_HC_CMD_ACK = 2;
    localparam int DSC_HC_CYC = 3;
endpackage

// file: src/dsc_pins_if.sv
// pin bundle between the serial controller device and its host
`timescale 1ns/100ps
interface dsc_pins_if;
    import dsc_pkg::*;
    logic [5:0] reg_select_lines;
    logic [7:0] host_data_dev;
    logic host_data_dev_oe_n;
    logic [7:0] host_data_host;
    logic host_data_host_oe_n;
    logic [7:0] host_data_lines;
    logic read_not_write;
    logic chip_select_n;
    logic irq_out_n_oe_n;
    logic irq_out_n;
    logic irq_ack_in_n;
    logic osc_out_or_chain_out;
    assign host_data_lines = !host_data_dev_oe_n ? host_data_dev :
        (!host_data_host_oe_n ? host_data_host : 8'hFF);
    assign irq_out_n = irq_out_n_oe_n ? 1'b1 : 1'b0;
    modport dev (
        input reg_select_lines, read_not_write, chip_select_n, irq_ack_in_n,
        input host_data_lines,
        output host_data_dev, host_data_dev_oe_n, irq_out_n_oe_n, osc_out_or_chain_out
    );
    modport host (
        output reg_select_lines, read_not_write, chip_select_n, irq_ack_in_n,
        output host_data_host, host_data_host_oe_n,
        input host_data_lines, irq_out_n, osc_out_or_chain_out
    );
endinterface

// file: src/dsc_device.sv
// dual channel serial controller device end
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
module dsc_device
    import dsc_pkg::*;
#(
    parameter int NCH = 2
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // host pins
    dsc_pins_if.dev bus,
    // line side, one bit per channel
    input wire logic [NCH-1:0] i_serial_rx_in,
    output logic [NCH-1:0] o_serial_tx_out,
    input wire logic [NCH-1:0] i_chan_clock_pin_a,
    output logic [NCH-1:0] o_chan_clock_pin_a,
    output logic [NCH-1:0] o_chan_clock_pin_a_oe_n,
    input wire logic [NCH-1:0] i_chan_clock_pin_b,
    output logic [NCH-1:0] o_chan_clock_pin_b,
    output logic [NCH-1:0] o_chan_clock_pin_b_oe_n,
    input wire logic [NCH-1:0] i_clear_to_send_n,
    output logic [NCH-1:0] o_loop_ctrl_out_n,
    output logic [NCH-1:0] o_loop_ctrl_out_n_oe_n
);
    logic [7:0] ctrl_r [NCH];
    logic [7:0] clksel_r [NCH];
    logic [7:0] txd_r [NCH];
    logic [7:0] rxd_r [NCH];
    logic [7:0] ie_r;
    logic [7:0] vec_r;
    logic [7:0] icr_r;
    logic [7:0] gsr_r;
    logic [7:0] gsr_set;
    logic [7:0] gsr_clr;
    logic [7:0] rd_data;
    logic pending;
    logic sel_rd;
    logic sel_wr;
    logic sel_wr_d_r;
    logic ack;
    logic [3:0] brg_cnt_r;
    logic brg_r;
    logic brg16_r;
    logic sys_r;
    logic [NCH-1:0] cts_s_r;
    logic [NCH-1:0] rxc_d_r;
    logic [NCH-1:0] txc_d_r;
    logic [NCH-1:0] rx_tick;
    logic [NCH-1:0] tx_tick;
    logic [NCH-1:0] tx_busy_r;
    logic [NCH-1:0] tx_bit_r;
    logic [NCH-1:0] tx_gate;
    logic [NCH-1:0] rx_busy_r;
    logic [NCH-1:0] txw;
    logic [NCH-1:0] rxr;
    logic [3:0] tx_cnt_r [NCH];
    logic [3:0] rx_cnt_r [NCH];
    logic [7:0] tx_sh_r [NCH];
    logic [7:0] rx_sh_r [NCH];

    assign sel_rd = !bus.chip_select_n && bus.read_not_write;
    assign sel_wr = !bus.chip_select_n && !bus.read_not_write;
    assign ack = !bus.irq_ack_in_n;
    assign pending = |(gsr_r & ie_r);

    // the osc input is the core clock; shared rate generator and system clock
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            brg_cnt_r <= 4'h0;
            brg_r <= 1'b0;
            brg16_r <= 1'b0;
            sys_r <= 1'b0;
        end else begin
            sys_r <= !sys_r;
            brg16_r <= !brg16_r;
            brg_cnt_r <= brg_cnt_r + 4'h1;
            if (brg_cnt_r == 4'(DSC_BRG_DIV - 1)) begin
                brg_cnt_r <= 4'h0;
                brg_r <= !brg_r;
            end
        end
    end

    // register select decode; a write lands on the first cycle of a strobe
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_wr_d_r <= 1'b0;
            ie_r <= 8'h00;
            vec_r <= DSC_VEC_RST;
            icr_r <= 8'h00;
            for (int c = 0; c < NCH; c++) begin
                ctrl_r[c] <= 8'h00;
                clksel_r[c] <= 8'h00;
                txd_r[c] <= 8'h00;
            end
        end else begin
            sel_wr_d_r <= sel_wr;
            if (sel_wr && !sel_wr_d_r) begin
                unique case (bus.reg_select_lines)
                    DSC_REG_CTRL_A: ctrl_r[0] <= bus.host_data_lines;
                    DSC_REG_CTRL_B: ctrl_r[1] <= bus.host_data_lines;
                    DSC_REG_CLKSEL_A: clksel_r[0] <= bus.host_data_lines;
                    DSC_REG_CLKSEL_B: clksel_r[1] <= bus.host_data_lines;
                    DSC_REG_IE: ie_r <= bus.host_data_lines;
                    DSC_REG_VEC: vec_r <= bus.host_data_lines;
                    DSC_REG_TXD_A: txd_r[0] <= bus.host_data_lines;
                    DSC_REG_TXD_B: txd_r[1] <= bus.host_data_lines;
                    DSC_REG_ICR: icr_r <= bus.host_data_lines;
                    default: ;
                endcase
            end
        end
    end

    assign txw[0] = sel_wr && !sel_wr_d_r && bus.reg_select_lines == DSC_REG_TXD_A;
    assign txw[1] = sel_wr && !sel_wr_d_r && bus.reg_select_lines == DSC_REG_TXD_B;
    assign rxr[0] = sel_rd && bus.reg_select_lines == DSC_REG_RXD_A;
    assign rxr[1] = sel_rd && bus.reg_select_lines == DSC_REG_RXD_B;
    assign gsr_clr = (sel_wr && !sel_wr_d_r && bus.reg_select_lines == DSC_REG_GSR) ?
        bus.host_data_lines : 8'h00;

    always_comb begin
        unique case (bus.reg_select_lines)
            DSC_REG_CTRL_A: rd_data = ctrl_r[0];
            DSC_REG_CTRL_B: rd_data = ctrl_r[1];
            DSC_REG_CLKSEL_A: rd_data = clksel_r[0];
            DSC_REG_CLKSEL_B: rd_data = clksel_r[1];
            DSC_REG_IE: rd_data = ie_r;
            DSC_REG_VEC: rd_data = vec_r;
            DSC_REG_RXD_A: rd_data = rxd_r[0];
            DSC_REG_RXD_B: rd_data = rxd_r[1];
            DSC_REG_GSR: rd_data = gsr_r;
            DSC_REG_ICR: rd_data = icr_r;
            default: rd_data = 8'h00;
        endcase
    end

    // bus drive: selected read without ack, or acknowledge with an interrupt pending unless the ack mode is float
    always_comb begin
        bus.host_data_dev = rd_data;
        bus.host_data_dev_oe_n = 1'b1;
        if (ack && pending) begin
            unique case (icr_r[DSC_ICR_ACKLO +: 2])
                DSC_ACK_FLOAT: bus.host_data_dev_oe_n = 1'b1;
                DSC_ACK_VECTOR: begin
                    bus.host_data_dev_oe_n = 1'b0;
                    bus.host_data_dev = icr_r[DSC_ICR_MODVEC] ?
                        {vec_r[7:3], 1'(gsr_r[DSC_ST_RXRDY_B] | gsr_r[DSC_ST_TXMT_B]), 2'h0} :
                        vec_r;
                end
                DSC_ACK_CALL: begin
                    bus.host_data_dev_oe_n = 1'b0;
                    bus.host_data_dev = DSC_CALL_OP;
                end
                DSC_ACK_ZERO: begin
                    bus.host_data_dev_oe_n = 1'b0;
                    bus.host_data_dev = 8'h00;
                end
            endcase
        end else if (sel_rd && !ack) begin
            bus.host_data_dev_oe_n = 1'b0;
        end
        // no pending interrupt: ack leaves the bus floating
    end

    assign bus.irq_out_n_oe_n = !pending;
    // chain out high (inactive) unless ack arrives and nothing is pending
    assign bus.osc_out_or_chain_out = icr_r[DSC_ICR_CHAIN] ?
        !(ack && !pending) : sys_r;

    // status flags: set wins over software clear
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gsr_r <= 8'h00;
        end else begin
            gsr_r <= (gsr_r & ~gsr_clr) | gsr_set;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cts_s_r <= '1;
            rxc_d_r <= '0;
            txc_d_r <= '0;
        end else begin
            cts_s_r <= i_clear_to_send_n;
            rxc_d_r <= i_chan_clock_pin_a;
            txc_d_r <= i_chan_clock_pin_b;
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        localparam int RB = (c == 0) ? DSC_ST_RXRDY_A : DSC_ST_RXRDY_B;
        localparam int TB = (c == 0) ? DSC_ST_TXMT_A : DSC_ST_TXMT_B;
        localparam int CB = (c == 0) ? DSC_ST_CTS_A : DSC_ST_CTS_B;
        logic bit_oriented_proto;
        assign bit_oriented_proto = ctrl_r[c][DSC_CTRL_BOPLOOP];
        // local loop feeds the receiver from the shifter, since the pin itself is held at mark
        logic rx_line;
        assign rx_line = ctrl_r[c][DSC_CTRL_LOCLOOP] ? tx_bit_r[c] : i_serial_rx_in[c];
        // external rx clock rising, tx clock falling; else rate generator
        assign rx_tick[c] = ctrl_r[c][DSC_CTRL_EXTRX] ?
            (i_chan_clock_pin_a[c] && !rxc_d_r[c]) : (brg_cnt_r == 4'h0 && brg_r);
        assign tx_tick[c] = ctrl_r[c][DSC_CTRL_EXTTX] ?
            (!i_chan_clock_pin_b[c] && txc_d_r[c]) : (brg_cnt_r == 4'h0 && !brg_r);
        assign tx_gate[c] = !ctrl_r[c][DSC_CTRL_CTSEN] || bit_oriented_proto || !i_clear_to_send_n[c];
        assign gsr_set[RB] = rx_tick[c] && rx_busy_r[c] && rx_cnt_r[c] == 4'h8;
        assign gsr_set[TB] = tx_tick[c] && tx_busy_r[c] && tx_cnt_r[c] == 4'h9;
        assign gsr_set[CB] = cts_s_r[c] != i_clear_to_send_n[c] && !bit_oriented_proto;
        assign gsr_set[CB+1] = 1'b0;

        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                tx_busy_r[c] <= 1'b0;
                tx_bit_r[c] <= 1'b1;
                tx_cnt_r[c] <= 4'h0;
                tx_sh_r[c] <= 8'h00;
            end else if (txw[c]) begin
                tx_busy_r[c] <= 1'b1;
                tx_cnt_r[c] <= 4'h0;
                tx_sh_r[c] <= bus.host_data_lines;
            end else if (tx_tick[c] && tx_busy_r[c] && tx_gate[c]) begin
                tx_cnt_r[c] <= tx_cnt_r[c] + 4'h1;
                if (tx_cnt_r[c] == 4'h0) begin
                    tx_bit_r[c] <= 1'b0;
                end else if (tx_cnt_r[c] == 4'h9) begin
                    tx_bit_r[c] <= 1'b1;
                    tx_busy_r[c] <= 1'b0;
                end else begin
                    tx_bit_r[c] <= tx_sh_r[c][0];
                    tx_sh_r[c] <= {1'b1, tx_sh_r[c][7:1]};
                end
            end
        end

        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                rx_busy_r[c] <= 1'b0;
                rx_cnt_r[c] <= 4'h0;
                rx_sh_r[c] <= 8'h00;
                rxd_r[c] <= 8'h00;
            end else if (rx_tick[c] && ctrl_r[c][DSC_CTRL_RXEN]) begin
                if (!rx_busy_r[c]) begin
                    rx_busy_r[c] <= !rx_line;
                    rx_cnt_r[c] <= 4'h0;
                end else if (rx_cnt_r[c] == 4'h8) begin
                    rx_busy_r[c] <= 1'b0;
                    rxd_r[c] <= rx_sh_r[c];
                end else begin
                    rx_cnt_r[c] <= rx_cnt_r[c] + 4'h1;
                    rx_sh_r[c] <= {rx_line, rx_sh_r[c][7:1]};
                end
            end
        end

        assign o_serial_tx_out[c] = (!ctrl_r[c][DSC_CTRL_TXEN] || ctrl_r[c][DSC_CTRL_LOCLOOP]) ?
            1'b1 : tx_bit_r[c];
        assign o_loop_ctrl_out_n_oe_n[c] = !bit_oriented_proto;
        assign o_loop_ctrl_out_n[c] = !ctrl_r[c][DSC_CTRL_LOOPON];

        always_comb begin
            o_chan_clock_pin_a_oe_n[c] = 1'b0;
            unique case (clksel_r[c][3:0])
                DSC_CK_CT: o_chan_clock_pin_a[c] = brg_r;
                DSC_CK_TX1X: o_chan_clock_pin_a[c] = tx_tick[c];
                DSC_CK_RX1X: o_chan_clock_pin_a[c] = rx_tick[c];
                default: begin
                    o_chan_clock_pin_a[c] = 1'b0;
                    o_chan_clock_pin_a_oe_n[c] = 1'b1;
                end
            endcase
            o_chan_clock_pin_b_oe_n[c] = 1'b0;
            unique case (clksel_r[c][7:4])
                DSC_CK_CT: o_chan_clock_pin_b[c] = brg_r;
                DSC_CK_TX1X: o_chan_clock_pin_b[c] = tx_tick[c];
                DSC_CK_RX1X: o_chan_clock_pin_b[c] = rx_tick[c];
                DSC_CK_PLL: o_chan_clock_pin_b[c] = rx_tick[c];
                DSC_CK_TX16: o_chan_clock_pin_b[c] = brg16_r;
                DSC_CK_RX16: o_chan_clock_pin_b[c] = brg16_r;
                DSC_CK_SYS: o_chan_clock_pin_b[c] = sys_r;
                default: begin
                    o_chan_clock_pin_b[c] = 1'b0;
                    o_chan_clock_pin_b_oe_n[c] = 1'b1;
                end
            endcase
        end
    end

endmodule // dsc_device

// file: src/dsc_host.sv
// host processor end: drives register cycles on the pins
`timescale 1ns/100ps
module dsc_host
    import dsc_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // software port
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_irq,
    // device pins
    dsc_pins_if.host bus
);
    typedef enum logic [1:0] {DSC_IDLE = 2'b00, DSC_CYC = 2'b01, DSC_DONE = 2'b11} dsc_hst_t;
    dsc_hst_t st_r;
    logic [5:0] addr_r;
    logic [7:0] wdat_r;
    logic [7:0] rdat_r;
    logic [2:0] cmd_r;
    logic [1:0] cnt_r;
    logic busy;

    assign busy = st_r != DSC_IDLE;

    // software registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_r <= 6'h00;
            wdat_r <= 8'h00;
        end else if (i_wr && i_addr == DSC_HC_ADDR) begin
            addr_r <= i_wdata[5:0];
        end else if (i_wr && i_addr == DSC_HC_DATA) begin
            wdat_r <= i_wdata;
        end
    end

    // a command is ignored while a cycle is running
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= DSC_IDLE;
            cmd_r <= 3'h0;
            cnt_r <= 2'h0;
            rdat_r <= 8'h00;
        end else begin
            unique case (st_r)
                DSC_IDLE: if (i_wr && i_addr == DSC_HC_CMD && i_wdata[2:0] != 3'h0) begin
                    cmd_r <= i_wdata[2:0];
                    cnt_r <= 2'h0;
                    st_r <= DSC_CYC;
                end
                DSC_CYC: begin
                    cnt_r <= cnt_r + 2'h1;
                    if (cnt_r == 2'(DSC_HC_CYC - 1)) begin
                        rdat_r <= bus.host_data_lines;
                        st_r <= DSC_DONE;
                    end
                end
                DSC_DONE: st_r <= DSC_IDLE;
                default: st_r <= DSC_IDLE;
            endcase
        end
    end

    // pins are held for the whole cycle; write data only when writing
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.chip_select_n <= 1'b1;
            bus.read_not_write <= 1'b1;
            bus.irq_ack_in_n <= 1'b1;
            bus.reg_select_lines <= 6'h00;
            bus.host_data_host <= 8'h00;
            bus.host_data_host_oe_n <= 1'b1;
        end else begin
            bus.reg_select_lines <= addr_r;
            bus.host_data_host <= wdat_r;
            if (st_r == DSC_IDLE && i_wr && i_addr == DSC_HC_CMD) begin
                bus.chip_select_n <= !(i_wdata[DSC_HC_CMD_RD] || i_wdata[DSC_HC_CMD_WR]);
                bus.read_not_write <= !i_wdata[DSC_HC_CMD_WR];
                bus.host_data_host_oe_n <= !i_wdata[DSC_HC_CMD_WR];
                bus.irq_ack_in_n <= !i_wdata[DSC_HC_CMD_ACK];
            end else if (st_r == DSC_DONE) begin
                bus.chip_select_n <= 1'b1;
                bus.read_not_write <= 1'b1;
                bus.host_data_host_oe_n <= 1'b1;
                bus.irq_ack_in_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= (i_addr == DSC_HC_STAT) ? {6'h00, !bus.irq_out_n, busy} :
                (i_addr == DSC_HC_DATA) ? rdat_r : {2'h0, addr_r};
        end
    end

    assign o_irq = !bus.irq_out_n;

endmodule // dsc_host

// file: verification/dsc_pins_assertions.sv
// pin bundle checker for the serial controller host and device ends
`timescale 1ns/100ps
module dsc_pins_assertions (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // pin bundle
    input wire logic [5:0] reg_select_lines,
    input wire logic host_data_dev_oe_n,
    input wire logic host_data_host_oe_n,
    input wire logic read_not_write,
    input wire logic chip_select_n,
    input wire logic irq_out_n_oe_n,
    input wire logic irq_ack_in_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr_sel;
        !chip_select_n && !read_not_write;
    endsequence
    sequence s_rd_sel;
        !chip_select_n && read_not_write;
    endsequence
    sequence s_sel_held;
        (!chip_select_n && $stable(reg_select_lines) && $stable(read_not_write))[*3];
    endsequence
    property p_bus_float;
        !host_data_dev_oe_n |-> (!chip_select_n && read_not_write) || !irq_ack_in_n;
    endproperty
    property p_wr_cycle;
        s_wr_sel |-> host_data_dev_oe_n && !host_data_host_oe_n;
    endproperty
    property p_rd_cycle;
        s_rd_sel |-> host_data_host_oe_n;
    endproperty
    property p_sel_hold;
        $fell(chip_select_n) |-> ##1 s_sel_held;
    endproperty
    property p_ack_idle;
        !irq_ack_in_n && irq_out_n_oe_n |-> host_data_dev_oe_n;
    endproperty
    property p_no_clash;
        host_data_dev_oe_n || host_data_host_oe_n;
    endproperty
    property p_reset_state;
        $rose(i_rst_n) |-> host_data_dev_oe_n && irq_out_n_oe_n && chip_select_n;
    endproperty
    property p_ack_alone;
        !irq_ack_in_n |-> chip_select_n;
    endproperty
    a_bus_float: assert property (p_bus_float) else $error("device drives bus unselected");
    a_wr_cycle: assert property (p_wr_cycle) else $error("write cycle bus owner wrong");
    a_rd_cycle: assert property (p_rd_cycle) else $error("host drives bus in read");
    a_sel_hold: assert property (p_sel_hold) else $error("select not held");
    a_ack_idle: assert property (p_ack_idle) else $error("ack answered with none pending");
    a_no_clash: assert property (p_no_clash) else $error("both ends drive data bus");
    a_reset_state: assert property (p_reset_state) else $error("pins not idle after reset");
    a_ack_alone: assert property (p_ack_alone) else $error("ack during select");
endmodule // dsc_pins_assertions

// file: verification/dsc_pin_interface_bench.sv
// self-checking bench: host and device ends joined by the pin bundle
`timescale 1ns/100ps
module dsc_pin_interface_bench;
    import dsc_pkg::*;
    logic i_core_clk, i_rst_n, wr, rd, irq, mark, chain, xck;
    logic [1:0] addr, cts_n, txd, ck_a_oe_n, ck_b_oe_n, lc_oe_n;
    logic [7:0] wdata, rdata, got;
    int num_errors, num_checks, cycles;
    logic [13:0] rows [4] = '{{DSC_REG_VEC, 8'h5A}, {DSC_REG_CLKSEL_A, 8'h70},
        {DSC_REG_ICR, 8'h01}, {DSC_REG_CTRL_B, 8'h00}};
    dsc_pins_if pins();
    dsc_device dsc_device_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .bus(pins),
        .i_serial_rx_in(txd), .o_serial_tx_out(txd), .i_chan_clock_pin_a({xck, 1'b0}),
        .o_chan_clock_pin_a(), .o_chan_clock_pin_a_oe_n(ck_a_oe_n),
        .i_chan_clock_pin_b({xck, 1'b0}), .o_chan_clock_pin_b(),
        .o_chan_clock_pin_b_oe_n(ck_b_oe_n),
        .i_clear_to_send_n(cts_n), .o_loop_ctrl_out_n(), .o_loop_ctrl_out_n_oe_n(lc_oe_n));
    dsc_host dsc_host_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .bus(pins));
    dsc_pins_assertions dsc_pins_assertions_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .reg_select_lines(pins.reg_select_lines), .host_data_dev_oe_n(pins.host_data_dev_oe_n),
        .host_data_host_oe_n(pins.host_data_host_oe_n), .read_not_write(pins.read_not_write),
        .chip_select_n(pins.chip_select_n), .irq_out_n_oe_n(pins.irq_out_n_oe_n),
        .irq_ack_in_n(pins.irq_ack_in_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one software port cycle; read data sampled in the cycle after the strobe
    task automatic sw(input logic [1:0] a, input logic [7:0] d, input logic r);
        @(posedge i_core_clk);
        addr <= a;
        wdata <= d;
        wr <= !r;
        rd <= r;
        @(posedge i_core_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 got = rdata;
    endtask
    // full device cycle: select, data, command, bounded busy poll, fetch result
    task automatic dev(input logic [5:0] r, input logic [7:0] d, input logic [7:0] cmd);
        sw(DSC_HC_ADDR, {2'b00, r}, 1'b0);
        sw(DSC_HC_DATA, d, 1'b0);
        sw(DSC_HC_CMD, cmd, 1'b0);
        got = 8'h01;
        for (int i = 0; i < 40 && got[0]; i++) sw(DSC_HC_STAT, 8'h00, 1'b1);
        sw(DSC_HC_DATA, 8'h00, 1'b1);
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        // chain output as seen while the acknowledge is held
        if (!pins.irq_ack_in_n) begin
            chain <= pins.osc_out_or_chain_out;
        end
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    initial begin
        {i_rst_n, wr, rd, addr, wdata, xck} = '0;
        // clear-to-send idles deasserted so release of reset shows no false change
        cts_n = 2'b11;
        repeat (20) @(posedge i_core_clk);
        #1 chk({6'h00, txd}, 8'h03);
        chk(pins.host_data_lines, 8'hFF);
        chk({7'h00, pins.irq_out_n}, 8'h01);
        chk({6'h00, lc_oe_n}, 8'h03);
        chk({7'h00, pins.osc_out_or_chain_out}, 8'h00);
        @(posedge i_core_clk) i_rst_n <= 1'b1;
        foreach (rows[i]) begin
            dev(rows[i][13:8], rows[i][7:0], 8'h02);
            dev(rows[i][13:8], 8'h00, 8'h01);
            chk(got, rows[i][7:0]);
        end
        chk({6'h00, ck_b_oe_n[0], ck_a_oe_n[0]}, 8'h01);
        // raw command so the start bit is not missed behind a busy poll
        dev(DSC_REG_CTRL_A, 8'h03, 8'h02);
        sw(DSC_HC_ADDR, {2'b00, DSC_REG_TXD_A}, 1'b0);
        sw(DSC_HC_DATA, 8'hA5, 1'b0);
        sw(DSC_HC_CMD, 8'h02, 1'b0);
        for (int i = 0; i < 100 && txd[0]; i++) #4;
        #32;
        for (int i = 0; i < 8; i++) #64 got[i] = txd[0];
        chk(got, 8'hA5);
        #200 dev(DSC_REG_RXD_A, 8'h00, 8'h01);
        chk(got, 8'hA5);
        dev(DSC_REG_IE, 8'h02, 8'h02);
        chk({7'h00, pins.irq_out_n}, 8'h00);
        chk({7'h00, irq}, 8'h01);
        dev(DSC_REG_VEC, 8'h00, 8'h04);
        chk(got, 8'h5A);
        dev(DSC_REG_GSR, 8'hFF, 8'h02);
        chk({7'h00, pins.irq_out_n}, 8'h01);
        dev(DSC_REG_ICR, 8'h09, 8'h02);
        dev(DSC_REG_VEC, 8'h00, 8'h04);
        chk(got, 8'hFF);
        chk({7'h00, chain}, 8'h00);
        chk({7'h00, pins.osc_out_or_chain_out}, 8'h01);
        @(posedge i_core_clk) cts_n <= 2'b01;
        #40 dev(DSC_REG_GSR, 8'h00, 8'h01);
        chk(got & 8'h40, 8'h40);
        // channel b on external clocks: tx shifts on falling, rx samples on rising
        dev(DSC_REG_CTRL_B, 8'hC3, 8'h02);
        dev(DSC_REG_TXD_B, 8'h5A, 8'h02);
        repeat (24) begin
            repeat (4) @(posedge i_core_clk);
            xck <= !xck;
        end
        dev(DSC_REG_RXD_B, 8'h00, 8'h01);
        chk(got, 8'h5A);
        // channel a gated by deasserted clear-to-send, channel b in local loop
        dev(DSC_REG_CTRL_A, 8'h0B, 8'h02);
        dev(DSC_REG_TXD_A, 8'h00, 8'h02);
        dev(DSC_REG_CTRL_B, 8'h05, 8'h02);
        dev(DSC_REG_TXD_B, 8'h00, 8'h02);
        mark = 1'b0;
        repeat (200) #4 mark |= !(&txd);
        chk({7'h00, mark}, 8'h00);
        final_report();
    end
endmodule // dsc_pin_interface_bench
